// ### rtl/mrc_ctrl.sv
// reset source controller: source filters, sequencer, flags, axi4-lite registers
`timescale 1ns/1ps
module mrc_ctrl #(
    parameter int RELEASE_CYC   = mrc_pkg::RELEASE_DELAY_CYC,
    parameter int BROWNOUT_CYC  = mrc_pkg::BROWNOUT_MIN_CYC,
    parameter int STARTUP_LONG  = mrc_pkg::STARTUP_LONG_CYC,
    parameter int STARTUP_SHORT = mrc_pkg::STARTUP_SHORT_CYC
)
(
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    input  wire logic [mrc_pkg::AXI_ADDR_W-1:0] awaddr,
    input  wire logic                          awvalid,
    output logic                               awready,
    input  wire logic [31:0]                   wdata,
    input  wire logic [3:0]                    wstrb,
    input  wire logic                          wvalid,
    output logic                               wready,
    output logic [1:0]                         bresp,
    output logic                               bvalid,
    input  wire logic                          bready,
    input  wire logic [mrc_pkg::AXI_ADDR_W-1:0] araddr,
    input  wire logic                          arvalid,
    output logic                               arready,
    output logic [31:0]                        rdata,
    output logic [1:0]                         rresp,
    output logic                               rvalid,
    input  wire logic                          rready,
    input  wire logic                          external_clear_pin_n,
    input  wire logic                          brownout_detector,
    input  wire logic                          watchdog_expiry,
    input  wire logic                          core_powerdown,
    input  wire logic                          powerdown_enter,
    input  wire logic                          flags_clear,
    input  wire logic                          cfg_brownout_en,
    input  wire logic [1:0]                    cfg_brownout_level,
    input  wire logic                          cfg_startup_wait_en,
    input  wire logic                          cfg_ext_crystal,
    output logic                               core_reset,
    output logic                               cold_clear,
    output logic                               pc_clear,
    output logic                               sp_top,
    output logic                               sp_zero,
    output logic                               wdt_clear,
    output logic [7:0]                         port_init_data,
    output logic [1:0]                         brownout_trip_level,
    output logic                               watchdog_expiry_flag,
    output logic                               powerdown_flag
);
    import mrc_pkg::*;

    if (RELEASE_CYC < 1 || BROWNOUT_CYC < 1 || STARTUP_SHORT < 1
        || STARTUP_LONG >= (1 << CNT_W) || STARTUP_SHORT >= (1 << CNT_W))
    begin : g_bad_counts
        $error("mrc_ctrl: cycle counts out of range");
    end

    mrc_state_e       state;
    mrc_state_e       next_state;
    mrc_cause_e       cause;
    mrc_cause_e       next_cause;
    logic [CNT_W-1:0] cnt;
    logic             warm;
    logic             opt_taken;
    logic             opt_bor_en;
    logic [1:0]       opt_lvl;
    logic             opt_wait_en;
    logic             opt_xtal;
    logic             pin_low_s;
    logic             bod_s;
    logic             soft_req;

    // pin and supply monitor are asynchronous to the core clock
    mrc_sync u_sync_pin (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (~external_clear_pin_n),
        .q       (pin_low_s)
    );
    mrc_sync u_sync_bod (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (brownout_detector),
        .q       (bod_s)
    );

    // trip needs the dip to outlast the minimum, hence one extra cycle
    mrc_hold_if bor_if ();
    assign bor_if.level = bod_s & opt_bor_en;
    mrc_hold #(.N(BROWNOUT_CYC + 1)) u_bor (
        .aclk    (aclk),
        .aresetn (aresetn),
        .hp      (bor_if.filt)
    );

    wire bor_trip = bor_if.held;
    wire hold_src = pin_low_s | bor_trip;

    mrc_hold_if rel_if ();
    assign rel_if.level = ~hold_src;
    mrc_hold #(.N(RELEASE_CYC)) u_rel (
        .aclk    (aclk),
        .aresetn (aresetn),
        .hp      (rel_if.filt)
    );

    wire [CNT_W-1:0] wait_len = (opt_xtal | opt_wait_en) ? CNT_W'(STARTUP_LONG)
                                                         : CNT_W'(STARTUP_SHORT);

    // events only count while running; in reset the watchdog is held clear
    wire running   = (state == ST_RUN);
    wire ev_hold   = running & hold_src;
    wire ev_wdt    = running & ~hold_src & watchdog_expiry;
    wire ev_wdt_pd = ev_wdt & core_powerdown;
    wire ev_wdt_nm = ev_wdt & ~core_powerdown;
    wire ev_soft   = running & ~hold_src & ~watchdog_expiry & soft_req;
    wire to_wait   = ev_wdt | ev_soft;
    wire wait_done = (state == ST_WAIT) & (cnt == '0);

    always_comb
    begin
        next_state = state;
        next_cause = cause;
        case (state)
            ST_RUN:
            begin
                if (ev_hold)
                begin
                    next_state = ST_HOLD;
                    next_cause = pin_low_s ? CAUSE_PIN : CAUSE_BROWN;
                end
                else if (to_wait)
                begin
                    next_state = ST_WAIT;
                    next_cause = ev_wdt_pd ? CAUSE_WDT_PD
                               : (ev_wdt ? CAUSE_WDT : CAUSE_SOFT);
                end
            end
            ST_HOLD:
            begin
                if (rel_if.held)
                    next_state = ST_WAIT;
            end
            ST_WAIT:
            begin
                if (hold_src)
                    next_state = ST_HOLD;
                else if (wait_done)
                    next_state = ST_RUN;
            end
            default:
            begin
                next_state = ST_HOLD;
            end
        endcase
    end

    wire next_in_reset = (next_state != ST_RUN);
    wire next_warm     = ev_wdt_pd ? 1'b1 : ((ev_hold | ev_wdt_nm | ev_soft) ? 1'b0 : warm);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= ST_HOLD;
            cause <= CAUSE_POWERON;
            warm  <= 1'b0;
            cnt   <= '0;
        end
        else
        begin
            state <= next_state;
            cause <= next_cause;
            warm  <= next_warm;
            cnt   <= (next_state == ST_WAIT && state != ST_WAIT) ? wait_len - 1'b1
                   : (cnt != '0 ? cnt - 1'b1 : cnt);
        end
    end

    // options are fuses: caught once just after reset release
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            opt_taken  <= 1'b0;
            opt_bor_en <= 1'b0;
            opt_lvl    <= 2'h0;
            opt_wait_en <= 1'b0;
            opt_xtal   <= 1'b0;
        end
        else if (!opt_taken)
        begin
            opt_taken  <= 1'b1;
            opt_bor_en <= cfg_brownout_en;
            opt_lvl    <= cfg_brownout_level;
            opt_wait_en <= cfg_startup_wait_en;
            opt_xtal   <= cfg_ext_crystal;
        end
    end

    // core-facing strobes, registered from the next state; port data and trip level come from a constant and the fuse
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            core_reset          <= 1'b1;
            cold_clear          <= 1'b1;
            pc_clear            <= 1'b1;
            sp_top              <= 1'b1;
            sp_zero             <= 1'b0;
            wdt_clear           <= 1'b1;
            port_init_data      <= PORT_RESET;
            brownout_trip_level <= 2'h0;
        end
        else
        begin
            core_reset          <= next_in_reset;
            cold_clear          <= next_in_reset & ~next_warm;
            pc_clear            <= next_in_reset;
            sp_top              <= next_in_reset & ~next_warm;
            sp_zero             <= next_in_reset & next_warm;
            wdt_clear           <= next_in_reset;
            port_init_data      <= PORT_RESET;
            brownout_trip_level <= opt_lvl;
        end
    end

    // flags: hardware set wins over any clear in the same cycle
    logic wr_commit;
    logic [7:0]  aw_q;
    logic [31:0] w_q;
    logic [3:0]  s_q;
    wire  wr_status = wr_commit & (aw_q == ADDR_STATUS) & s_q[0];
    wire  clr_expiry = flags_clear | (wr_status & w_q[ST_WDT_BIT]);
    wire  clr_pwrdn  = flags_clear | (wr_status & w_q[ST_PWRDN_BIT]);
    wire  set_pwrdn  = ev_wdt_pd | powerdown_enter;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            watchdog_expiry_flag <= 1'b0;
            powerdown_flag       <= 1'b0;
        end
        else
        begin
            watchdog_expiry_flag <= ev_wdt | (watchdog_expiry_flag & ~clr_expiry);
            powerdown_flag       <= set_pwrdn | (powerdown_flag & ~clr_pwrdn);
        end
    end

    // axi4-lite write: address and data taken in either order
    assign wr_commit = ~awready & ~wready & ~bvalid;
    wire   wr_hit    = (aw_q == ADDR_CTRL) | (aw_q == ADDR_STATUS) | (aw_q == ADDR_CONFIG);
    assign soft_req  = wr_commit & (aw_q == ADDR_CTRL) & s_q[0] & w_q[CTRL_SOFT_BIT];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
            aw_q    <= 8'h00;
            w_q     <= 32'h0;
            s_q     <= 4'h0;
        end
        else
        begin
            if (awready && awvalid)
            begin
                awready <= 1'b0;
                aw_q    <= awaddr;
            end
            if (wready && wvalid)
            begin
                wready <= 1'b0;
                w_q    <= wdata;
                s_q    <= wstrb;
            end
            if (wr_commit)
            begin
                bvalid <= 1'b1;
                bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid && bready)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // axi4-lite read
    logic [31:0] status_word;
    logic [31:0] config_word;
    always_comb
    begin
        status_word = 32'h0;
        status_word[ST_WDT_BIT]         = watchdog_expiry_flag;
        status_word[ST_PWRDN_BIT]       = powerdown_flag;
        status_word[ST_CAUSE_LSB +: 3]  = cause;
        status_word[ST_BUSY_BIT]        = core_reset;
        config_word = 32'h0;
        config_word[CFG_BOR_EN_BIT]     = opt_bor_en;
        config_word[CFG_LVL_LSB +: 2]   = opt_lvl;
        config_word[CFG_WAIT_EN_BIT]    = opt_wait_en;
        config_word[CFG_XTAL_BIT]       = opt_xtal;
    end

    wire        rd_status = (araddr == ADDR_STATUS);
    wire        rd_config = (araddr == ADDR_CONFIG);
    wire        rd_hit    = rd_status | rd_config | (araddr == ADDR_CTRL);
    wire [31:0] rd_word   = rd_status ? status_word : (rd_config ? config_word : 32'h0);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0;
            rresp   <= RESP_OKAY;
        end
        else if (arready && arvalid)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_word;
            rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid && rready)
        begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // helper counters seen only by the checks below
    localparam int REL_N = RELEASE_CYC;
    localparam int BOR_N = BROWNOUT_CYC;
    int quiet_run;
    int dip_run;
    int wait_run;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            quiet_run <= 0;
            dip_run   <= 0;
            wait_run  <= 0;
        end
        else
        begin
            quiet_run <= hold_src ? 0 : quiet_run + 1;
            dip_run   <= (bod_s && opt_bor_en) ? dip_run + 1 : 0;
            wait_run  <= (state == ST_WAIT) ? wait_run + 1 : 0;
        end
    end

    a_pin_holds_core: assert property (@(posedge aclk) disable iff (!aresetn)
        pin_low_s |=> core_reset ##1 core_reset)
        else $error("core left reset while clear pin low");
    a_release_wait: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == ST_HOLD && next_state == ST_WAIT) |-> quiet_run >= REL_N - 1)
        else $error("release delay cut short");
    a_pin_restart: assert property (@(posedge aclk) disable iff (!aresetn)
        (running && pin_low_s) |=> (pc_clear && cold_clear && state == ST_HOLD))
        else $error("clear pin did not restart core");
    a_short_dip: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(bor_trip) |-> $past(dip_run) == BOR_N)
        else $error("brownout trip after wrong duration");
    a_brownout_off: assert property (@(posedge aclk) disable iff (!aresetn)
        (opt_taken && !opt_bor_en) |-> ##2 !bor_trip)
        else $error("disabled brownout tripped");
    a_wdt_normal: assert property (@(posedge aclk) disable iff (!aresetn)
        ev_wdt_nm |=> (watchdog_expiry_flag && cold_clear && core_reset && !sp_zero))
        else $error("watchdog normal reset wrong");
    a_warm_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        ev_wdt_pd |=> (sp_zero && pc_clear && !cold_clear && powerdown_flag
                       && watchdog_expiry_flag))
        else $error("warm reset wrong");
    a_startup_len: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == ST_WAIT && next_state == ST_RUN) |-> (wait_run + 1 == int'(wait_len)))
        else $error("startup wait length wrong");
    a_por_flags: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> (!watchdog_expiry_flag && !powerdown_flag))
        else $error("flags not cleared by power-on");
    a_pin_keeps_flags: assert property (@(posedge aclk) disable iff (!aresetn)
        (ev_hold && !flags_clear && !powerdown_enter && !wr_commit)
        |=> ($stable(watchdog_expiry_flag) && $stable(powerdown_flag)))
        else $error("pin reset changed flags");
    a_cold_state: assert property (@(posedge aclk) disable iff (!aresetn)
        cold_clear |-> (sp_top && !sp_zero && port_init_data == PORT_RESET))
        else $error("cold reset presets wrong");
    a_wdt_restart: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(core_reset) |-> (!wdt_clear && $past(wdt_clear)))
        else $error("watchdog not released with core");
    a_pc_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        core_reset |-> pc_clear)
        else $error("reset without program counter clear");
    a_one_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        bor_trip |=> core_reset)
        else $error("brownout did not reset core");

    c_pin_reset: cover property (@(posedge aclk) disable iff (!aresetn)
        ev_hold && pin_low_s ##[1:400] $fell(core_reset));
    c_brownout: cover property (@(posedge aclk) disable iff (!aresetn) ev_hold && !pin_low_s);
    c_warm: cover property (@(posedge aclk) disable iff (!aresetn) ev_wdt_pd);
    c_soft: cover property (@(posedge aclk) disable iff (!aresetn) ev_soft);
endmodule // mrc_ctrl

// ### rtl/mrc_hold.sv
// reports a level that has stood high for n consecutive cycles
`timescale 1ns/1ps
module mrc_hold #(
    parameter int N = 1
)
(
    input  wire logic aclk,
    input  wire logic aresetn,
    mrc_hold_if.filt  hp
);
    import mrc_pkg::*;
    localparam int CW = $clog2(N + 1);
    logic [CW-1:0] run;

    if (N < 1)
    begin : g_bad_n
        $error("mrc_hold: N must be at least 1");
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !hp.level)
            run <= '0;
        else if (run != CW'(N))
            run <= run + 1'b1;
    end

    assign hp.held = (run == CW'(N));
endmodule // mrc_hold

// ### rtl/mrc_hold_if.sv
// level and its held-long-enough answer between controller and filter
`timescale 1ns/1ps
interface mrc_hold_if;
    logic level;
    logic held;
    modport filt (input level, output held);
    modport user (output level, input held);
endinterface

// ### rtl/mrc_pkg.sv
// shared constants and types of the reset source controller
package mrc_pkg;
    localparam int          CLK_PERIOD_NS     = 10;
    localparam int          RELEASE_DELAY_NS  = 1000;
    localparam int          RELEASE_DELAY_CYC =
        (RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          BROWNOUT_MIN_NS   = 1000;
    localparam int          BROWNOUT_MIN_CYC  =
        (BROWNOUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          STARTUP_LONG_CYC  = 1024;
    localparam int          STARTUP_SHORT_CYC = 2;
    localparam int          CNT_W             = 16;
    localparam logic [7:0]  PORT_RESET        = 8'hff;
    localparam int          AXI_ADDR_W        = 8;
    localparam logic [7:0]  ADDR_CTRL         = 8'h00;
    localparam logic [7:0]  ADDR_STATUS       = 8'h04;
    localparam logic [7:0]  ADDR_CONFIG       = 8'h08;
    localparam int          CTRL_SOFT_BIT     = 0;
    localparam int          ST_WDT_BIT        = 0;
    localparam int          ST_PWRDN_BIT      = 1;
    localparam int          ST_CAUSE_LSB      = 2;
    localparam int          ST_BUSY_BIT       = 5;
    localparam int          CFG_BOR_EN_BIT    = 0;
    localparam int          CFG_LVL_LSB       = 1;
    localparam int          CFG_WAIT_EN_BIT   = 3;
    localparam int          CFG_XTAL_BIT      = 4;
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;

    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_HOLD = 2'b01,
        ST_WAIT = 2'b10
    } mrc_state_e;

    typedef enum logic [2:0] {
        CAUSE_POWERON = 3'b000,
        CAUSE_PIN     = 3'b001,
        CAUSE_BROWN   = 3'b010,
        CAUSE_WDT     = 3'b011,
        CAUSE_WDT_PD  = 3'b100,
        CAUSE_SOFT    = 3'b101
    } mrc_cause_e;
endpackage

// ### rtl/mrc_sync.sv
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
module mrc_sync
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic d,
    output logic      q
);
    import mrc_pkg::*;
    logic meta;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta <= 1'b0;
            q    <= 1'b0;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // mrc_sync

// ### verif/mrc_supply_model.sv
// rc reset network and supply monitor facing the reset controller
`timescale 1ns/1ps
module mrc_supply_model
(
    input  wire logic clear_hold,
    input  wire logic supply_dip,
    output logic      external_clear_pin_n,
    output logic      brownout_detector
);
    // pull-up lifts the pin once the switch lets go
    assign external_clear_pin_n = !clear_hold;
    assign brownout_detector    = supply_dip;
endmodule // mrc_supply_model

// ### verif/testbench.sv
// self-checking bench for the reset source controller
`timescale 1ns/1ps
module testbench;
    import mrc_pkg::*;
    localparam int REL = 3;
    localparam int LNG = 8;
    logic        aclk = 0;
    logic        aresetn = 0;
    logic [7:0]  awaddr = 0;
    logic [7:0]  araddr = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0;
    logic [3:0]  wstrb = 0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, brownout_trip_level, resp;
    logic [31:0] rdata, rd;
    logic        external_clear_pin_n, brownout_detector;
    logic        watchdog_expiry = 0, core_powerdown = 0, powerdown_enter = 0, flags_clear = 0;
    logic        cfg_brownout_en = 1, cfg_startup_wait_en = 1, cfg_ext_crystal = 0;
    logic [1:0]  cfg_brownout_level = 2'h2;
    logic        clear_hold = 1, supply_dip = 0;
    logic        core_reset, cold_clear, pc_clear, sp_top, sp_zero, wdt_clear;
    logic        watchdog_expiry_flag, powerdown_flag;
    logic [7:0]  port_init_data;
    int          errors = 0, n_compared = 0, n;
    wire  [7:0]  ctl = {core_reset, cold_clear, pc_clear, sp_top, sp_zero, wdt_clear,
                        watchdog_expiry_flag, powerdown_flag};
    always #5 aclk = ~aclk;
    mrc_supply_model partner (.clear_hold, .supply_dip, .external_clear_pin_n,
                              .brownout_detector);
    // short counts keep each restart brief
    mrc_ctrl #(.RELEASE_CYC(REL), .BROWNOUT_CYC(3), .STARTUP_LONG(LNG), .STARTUP_SHORT(2)) DUT (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .external_clear_pin_n, .brownout_detector, .watchdog_expiry,
        .core_powerdown, .powerdown_enter, .flags_clear, .cfg_brownout_en,
        .cfg_brownout_level, .cfg_startup_wait_en, .cfg_ext_crystal, .core_reset,
        .cold_clear, .pc_clear, .sp_top, .sp_zero, .wdt_clear, .port_init_data,
        .brownout_trip_level, .watchdog_expiry_flag, .powerdown_flag);
    task automatic complete_run;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            errors++;
        end
    endtask
    // outputs are read 1 ns after the edge so its updates have landed
    task automatic step(input int k);
        repeat (k) @(posedge aclk);
        #1;
    endtask
    task automatic wait_core(input logic v);
        n = 0;
        while (core_reset !== v && n < 300)
        begin
            step(1);
            n++;
        end
        if (n == 300)
            chk(core_reset, v);
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if (bvalid)
            begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
            if (rvalid)
            begin
                rd = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
        axr(a);
        chk(rd, e);
    endtask
    task automatic dip(input int k);
        @(posedge aclk);
        supply_dip <= 1'b1;
        repeat (k) @(posedge aclk);
        supply_dip <= 1'b0;
    endtask
    task automatic bark;
        @(posedge aclk);
        watchdog_expiry <= 1'b1;
        @(posedge aclk);
        watchdog_expiry <= 1'b0;
    endtask
    initial
    begin
        #300us;
        errors++;
        complete_run;
    end
    initial
    begin
        step(10);
        chk(ctl, 8'hf4);
        chk(port_init_data, 8'hff);
        @(posedge aclk);
        aresetn    <= 1'b1;
        clear_hold <= 1'b0;
        wait_core(1'b0);
        chk(n >= REL + LNG && n < REL + LNG + 8, 1'b1);
        chk(ctl, 8'h00);
        chk(brownout_trip_level, 2'h2);
        chk_reg(ADDR_CONFIG, 32'h0d);
        @(posedge aclk);
        clear_hold <= 1'b1;
        wait_core(1'b1);
        step(20);
        chk(ctl, 8'hf4);
        @(posedge aclk);
        clear_hold <= 1'b0;
        wait_core(1'b0);
        chk(n >= REL + LNG, 1'b1);
        chk_reg(ADDR_STATUS, 32'h04);
        // two synced cycles is below the minimum duration
        dip(2);
        step(10);
        chk(core_reset, 1'b0);
        dip(10);
        step(1);
        chk(ctl, 8'hf4);
        wait_core(1'b0);
        chk_reg(ADDR_STATUS, 32'h08);
        bark;
        wait_core(1'b1);
        chk(ctl, 8'hf6);
        wait_core(1'b0);
        chk_reg(ADDR_STATUS, 32'h0d);
        axw(ADDR_STATUS, 32'h1);
        chk(resp, RESP_OKAY);
        chk_reg(ADDR_STATUS, 32'h0c);
        @(posedge aclk);
        powerdown_enter <= 1'b1;
        core_powerdown  <= 1'b1;
        @(posedge aclk);
        powerdown_enter <= 1'b0;
        bark;
        wait_core(1'b1);
        chk(ctl, 8'haf);
        @(posedge aclk);
        core_powerdown <= 1'b0;
        wait_core(1'b0);
        chk_reg(ADDR_STATUS, 32'h13);
        // pin reset with both flags up must leave them alone
        @(posedge aclk);
        clear_hold <= 1'b1;
        wait_core(1'b1);
        @(posedge aclk);
        clear_hold <= 1'b0;
        wait_core(1'b0);
        chk_reg(ADDR_STATUS, 32'h07);
        @(posedge aclk);
        flags_clear <= 1'b1;
        @(posedge aclk);
        flags_clear <= 1'b0;
        step(2);
        chk({watchdog_expiry_flag, powerdown_flag}, 2'h0);
        axr(8'h0c);
        chk(resp, RESP_SLVERR);
        axw(8'h10, 32'h1);
        chk(resp, RESP_SLVERR);
        axw(ADDR_CTRL, 32'h1);
        chk(resp, RESP_OKAY);
        wait_core(1'b1);
        step(1);
        chk(ctl, 8'hf4);
        wait_core(1'b0);
        chk_reg(ADDR_STATUS, 32'h14);
        // fuses are only taken at reset release
        @(posedge aclk);
        aresetn             <= 1'b0;
        cfg_brownout_en     <= 1'b0;
        cfg_startup_wait_en <= 1'b0;
        step(10);
        @(posedge aclk);
        aresetn <= 1'b1;
        wait_core(1'b0);
        chk(n < REL + LNG, 1'b1);
        dip(10);
        step(5);
        chk(core_reset, 1'b0);
        // crystal clock forces the long wait whatever the option says
        @(posedge aclk);
        aresetn         <= 1'b0;
        cfg_ext_crystal <= 1'b1;
        step(10);
        @(posedge aclk);
        aresetn <= 1'b1;
        wait_core(1'b0);
        chk(n >= REL + LNG, 1'b1);
        chk_reg(ADDR_CONFIG, 32'h14);
        complete_run;
    end
endmodule // testbench
